// *** hw/zsrg_defs.vh ***
// Constants for the zone-select restart guard: register map, reset values, codes, timing.
// Assumes a 25 MHz system clock; included by the zsrg_guard module only.
// Notes on behaviour
// - a reset press counts only when held from 0.12 s to 4 s.
// - with start interlock, outputs stay off after power-up until a valid press.
// - with restart interlock, outputs stay off after a cleared intrusion until a press.
// - restart interlock always implies start interlock at power-up.
// - eight zone sets; the selection may change at any time.
// - a broken changeover signals a fault, a diagnostic code and outputs off.
// - fixed mode monitors only the default zone set, ignoring select inputs.
// - in input mode any select input change starts the switchover timer.
// - while the timer runs the previous zone set stays monitored.
// - the new zone set is monitored only once the timer has expired.
// - into an occupied zone, outputs drop after 25 ms plus switchover plus response.
// - four inputs decode 1000,0100,0010,0001,1110,1101,1011,0111 as sets 1 to 8.
// - three inputs decode 001,010,100,111 as sets 1 to 4.
// - two inputs decode 10 as set 1 and 01 as set 2.
// - with sequence monitoring, any unlisted transition but the first after reset or fixed mode turns the outputs off.
// - with sequence monitoring, a deactivated target set turns the outputs off.
// - a violated monitored protective zone switches both outputs off.
`ifndef ZSRG_DEFS_VH
`define ZSRG_DEFS_VH

`define ZS_A_CTRL      8'h00
`define ZS_A_SWTIME    8'h04
`define ZS_A_RESP      8'h08
`define ZS_A_ALLOW_LO  8'h0C
`define ZS_A_ALLOW_HI  8'h10
`define ZS_A_DEACT     8'h14
`define ZS_A_STATUS    8'h18

`define ZS_C_START     0
`define ZS_C_RESTART   1
`define ZS_C_MODE_LO   2
`define ZS_C_MODE_HI   3
`define ZS_C_SEQ_EN    4

`define ZS_CTRL_RST    5'h03
`define ZS_SWT_RST     24'h0061A8
`define ZS_RESP_RST    24'h001388
`define ZS_ALLOW_RST   32'hFFFFFFFF
`define ZS_DEACT_RST   8'h00

`define ZS_MODE_FIXED  2'h0
`define ZS_MODE_TWO    2'h1
`define ZS_MODE_THREE  2'h2
`define ZS_MODE_FOUR   2'h3

`define ZS_DIAG_NONE   4'h0
`define ZS_DIAG_PAT    4'h1
`define ZS_DIAG_SEQ    4'h2
`define ZS_DIAG_DEACT  4'h3

`define ZS_CLK_KHZ       25000
`define ZS_PRESS_MIN_MS  120
`define ZS_PRESS_MAX_MS  4000
`define ZS_SYNC_MS       25

`endif

// *** hw/zsrg_sync2.v ***
// Two-stage synchroniser for a group of asynchronous pin inputs.
// Assumes the inputs are quasi-static levels; bits are not aligned to each other.
`timescale 1ns/10ps
module zsrg_sync2 #(
  parameter W = 1
) (
  input  wire         sys_clk,
  input  wire         rst_b,
  input  wire [W-1:0] din,
  output wire [W-1:0] dout
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;
endmodule // zsrg_sync2

// *** hw/zsrg_press.v ***
// Reset-button press qualifier: one-cycle pulse on release of a press of legal length.
// Assumes btn is already synchronised to sys_clk.
`timescale 1ns/10ps
module zsrg_press #(
  parameter W       = 27,
  parameter MIN_CYC = 3000000,
  parameter MAX_CYC = 100000000
) (
  input  wire sys_clk,
  input  wire rst_b,
  input  wire btn,
  output reg  valid_q
);
  localparam [W-1:0] MIN_W = MIN_CYC[W-1:0];
  localparam [W-1:0] MAX_W = MAX_CYC[W-1:0];

  reg [W-1:0] cnt_q;
  reg         btn_q;

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q   <= {W{1'b0}};
      btn_q   <= 1'b0;
      valid_q <= 1'b0;
    end else begin
      btn_q <= btn;
      // saturate just past the limit so an overlong press can never wrap back into range
      if (btn && cnt_q <= MAX_W)
        cnt_q <= cnt_q + 1'b1;
      else if (!btn)
        cnt_q <= {W{1'b0}};
      valid_q <= btn_q && !btn && cnt_q >= MIN_W && cnt_q <= MAX_W;
    end
  end
endmodule // zsrg_press

// *** hw/zsrg_guard.v ***
// Zone-select restart guard top: interlocks, zone-set changeover, register port.
// Assumes violation flags come from field logic on sys_clk; buttons and selects are pins.
`timescale 1ns/10ps
`include "zsrg_defs.vh"
module zsrg_guard #(
  parameter PRESS_MIN_CYC = `ZS_PRESS_MIN_MS * `ZS_CLK_KHZ,
  parameter PRESS_MAX_CYC = `ZS_PRESS_MAX_MS * `ZS_CLK_KHZ,
  parameter SYNC_CYC      = `ZS_SYNC_MS * `ZS_CLK_KHZ
) (
  input  wire        sys_clk,
  input  wire        rst_b,
  input  wire        reset_btn,
  input  wire        zone_sel_in_1,
  input  wire        zone_sel_in_2,
  input  wire        zone_sel_in_3,
  input  wire        zone_sel_in_4,
  input  wire [7:0]  zone_violated,
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata_q,
  output reg  [1:0]  safety_output_pair_q,
  output reg  [2:0]  active_set_q,
  output reg         fault_q,
  output reg  [3:0]  diag_code_q
);

  localparam [1:0] ST_LOCK  = 2'h0;
  localparam [1:0] ST_RUN   = 2'h1;
  localparam [1:0] ST_OFF   = 2'h2;
  localparam [1:0] ST_FAULT = 2'h3;

  localparam [25:0] SYNC_W = SYNC_CYC[25:0];

  // returns {valid, set index}
  function [3:0] zs_decode;
    input [1:0] mode;
    input [3:0] p;
    begin
      zs_decode = 4'h0;
      case (mode)
        `ZS_MODE_FOUR: begin
          case (p)
            4'h8: zs_decode = 4'h8;
            4'h4: zs_decode = 4'h9;
            4'h2: zs_decode = 4'hA;
            4'h1: zs_decode = 4'hB;
            4'hE: zs_decode = 4'hC;
            4'hD: zs_decode = 4'hD;
            4'hB: zs_decode = 4'hE;
            4'h7: zs_decode = 4'hF;
            default: zs_decode = 4'h0;
          endcase
        end
        `ZS_MODE_THREE: begin
          case (p[3:1])
            3'h1: zs_decode = 4'h8;
            3'h2: zs_decode = 4'h9;
            3'h4: zs_decode = 4'hA;
            3'h7: zs_decode = 4'hB;
            default: zs_decode = 4'h0;
          endcase
        end
        `ZS_MODE_TWO: begin
          case (p[3:2])
            2'h2: zs_decode = 4'h8;
            2'h1: zs_decode = 4'h9;
            default: zs_decode = 4'h0;
          endcase
        end
        default: zs_decode = 4'h8;
      endcase
    end
  endfunction

  // input synchronisation
  wire [4:0] pins_s;
  wire       btn_s;
  wire [3:0] pat_s;
  wire       press_ok;

  zsrg_sync2 #(
    .W (5)
  ) u_sync (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .din     ({reset_btn, zone_sel_in_1, zone_sel_in_2, zone_sel_in_3, zone_sel_in_4}),
    .dout    (pins_s)
  );

  assign btn_s = pins_s[4];
  assign pat_s = pins_s[3:0];

  zsrg_press #(
    .W       (27),
    .MIN_CYC (PRESS_MIN_CYC),
    .MAX_CYC (PRESS_MAX_CYC)
  ) u_press (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .btn     (btn_s),
    .valid_q (press_ok)
  );

  // configuration registers
  reg [4:0]  ctrl_q;
  reg [23:0] swtime_q;
  reg [23:0] resp_q;
  reg [31:0] allow_lo_q;
  reg [31:0] allow_hi_q;
  reg [7:0]  deact_q;

  wire [1:0] mode     = ctrl_q[`ZS_C_MODE_HI:`ZS_C_MODE_LO];
  wire       start_il = ctrl_q[`ZS_C_START] | ctrl_q[`ZS_C_RESTART];
  wire       seq_en   = ctrl_q[`ZS_C_SEQ_EN];
  wire [63:0] allow_all = {allow_hi_q, allow_lo_q};

  // changeover state
  reg        sw_busy_q;
  reg [23:0] sw_cnt_q;
  reg [25:0] hold_cnt_q;
  reg [3:0]  commit_pat_q;
  reg [3:0]  pat_prev_q;
  reg        first_q;
  reg [1:0]  state_q;
  reg [1:0]  state_d;

  wire [3:0] dec      = zs_decode(mode, pat_s);
  wire       sw_exp   = sw_busy_q && sw_cnt_q == 24'h000000;
  wire       stable   = dec[3] && pat_s == pat_prev_q;
  wire       seq_bad  = seq_en && !first_q && !allow_all[{active_set_q, dec[2:0]}];
  wire       deact_bd = seq_en && deact_q[dec[2:0]];
  reg  [3:0] diag_ev;

  always @* begin
    diag_ev = `ZS_DIAG_NONE;
    if (sw_exp) begin
      if (!stable)
        diag_ev = `ZS_DIAG_PAT;
      else if (seq_bad)
        diag_ev = `ZS_DIAG_SEQ;
      else if (deact_bd)
        diag_ev = `ZS_DIAG_DEACT;
    end
  end

  wire fault_ev = diag_ev != `ZS_DIAG_NONE;

  // the new set is blind until sync plus response time has passed after taking over
  wire viol = zone_violated[active_set_q] && hold_cnt_q == 26'h0000000;

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sw_busy_q    <= 1'b0;
      sw_cnt_q     <= 24'h000000;
      hold_cnt_q   <= 26'h0000000;
      commit_pat_q <= 4'h0;
      pat_prev_q   <= 4'h0;
      first_q      <= 1'b1;
      active_set_q <= 3'h0;
    end else begin
      pat_prev_q <= pat_s;
      if (hold_cnt_q != 26'h0000000)
        hold_cnt_q <= hold_cnt_q - 1'b1;
      if (mode == `ZS_MODE_FIXED) begin
        active_set_q <= 3'h0;
        sw_busy_q    <= 1'b0;
        commit_pat_q <= pat_s;
        first_q      <= 1'b1;
      end else if (!sw_busy_q && pat_s != commit_pat_q) begin
        sw_busy_q <= 1'b1;
        sw_cnt_q  <= swtime_q;
      end else if (sw_busy_q && !sw_exp) begin
        sw_cnt_q <= sw_cnt_q - 1'b1;
      end else if (sw_exp) begin
        sw_busy_q    <= 1'b0;
        commit_pat_q <= pat_s;
        if (!fault_ev) begin
          active_set_q <= dec[2:0];
          first_q      <= 1'b0;
          hold_cnt_q   <= SYNC_W + {2'h0, resp_q};
        end
      end
    end
  end

  // interlock state machine
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_LOCK: begin
        if (fault_ev)
          state_d = ST_FAULT;
        else if (!start_il && !viol)
          state_d = ST_RUN;
        else if (press_ok && !viol)
          state_d = ST_RUN;
      end
      ST_RUN: begin
        if (fault_ev)
          state_d = ST_FAULT;
        else if (viol)
          state_d = ST_OFF;
      end
      ST_OFF: begin
        if (fault_ev)
          state_d = ST_FAULT;
        else if (!viol)
          state_d = ctrl_q[`ZS_C_RESTART] ? ST_LOCK : ST_RUN;
      end
      default: state_d = ST_FAULT;
    endcase
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q              <= ST_LOCK;
      safety_output_pair_q <= 2'h0;
      fault_q              <= 1'b0;
      diag_code_q          <= `ZS_DIAG_NONE;
    end else begin
      state_q              <= state_d;
      safety_output_pair_q <= {2{state_d == ST_RUN}};
      if (fault_ev && !fault_q) begin
        fault_q     <= 1'b1;
        diag_code_q <= diag_ev;
      end
    end
  end

  // register port; reads answer one cycle later, unmapped reads give zero
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q      <= `ZS_CTRL_RST;
      swtime_q    <= `ZS_SWT_RST;
      resp_q      <= `ZS_RESP_RST;
      allow_lo_q  <= `ZS_ALLOW_RST;
      allow_hi_q  <= `ZS_ALLOW_RST;
      deact_q     <= `ZS_DEACT_RST;
      reg_rdata_q <= 32'h00000000;
    end else begin
      if (reg_wr) begin
        if (reg_addr == `ZS_A_CTRL)
          ctrl_q <= reg_wdata[4:0];
        else if (reg_addr == `ZS_A_SWTIME)
          swtime_q <= reg_wdata[23:0];
        else if (reg_addr == `ZS_A_RESP)
          resp_q <= reg_wdata[23:0];
        else if (reg_addr == `ZS_A_ALLOW_LO)
          allow_lo_q <= reg_wdata;
        else if (reg_addr == `ZS_A_ALLOW_HI)
          allow_hi_q <= reg_wdata;
        else if (reg_addr == `ZS_A_DEACT)
          deact_q <= reg_wdata[7:0];
      end
      reg_rdata_q <= 32'h00000000;
      if (reg_rd) begin
        if (reg_addr == `ZS_A_CTRL)
          reg_rdata_q <= {27'h0, ctrl_q};
        else if (reg_addr == `ZS_A_SWTIME)
          reg_rdata_q <= {8'h00, swtime_q};
        else if (reg_addr == `ZS_A_RESP)
          reg_rdata_q <= {8'h00, resp_q};
        else if (reg_addr == `ZS_A_ALLOW_LO)
          reg_rdata_q <= allow_lo_q;
        else if (reg_addr == `ZS_A_ALLOW_HI)
          reg_rdata_q <= allow_hi_q;
        else if (reg_addr == `ZS_A_DEACT)
          reg_rdata_q <= {24'h0, deact_q};
        else if (reg_addr == `ZS_A_STATUS)
          reg_rdata_q <= {19'h0, diag_code_q, state_q, sw_busy_q, fault_q,
                          safety_output_pair_q, active_set_q};
      end
    end
  end
endmodule // zsrg_guard

// *** dv/zsrg_checker.sv ***
// Checker for zsrg_guard: interlock, fault and output relations.
// Assumes it is bound into zsrg_guard and sees only its ports.
`timescale 1ns/10ps
module zsrg_checker (
  input wire        sys_clk,
  input wire        rst_b,
  input wire        reset_btn,
  input wire [7:0]  zone_violated,
  input wire [7:0]  reg_addr,
  input wire        reg_wr,
  input wire [1:0]  safety_output_pair_q,
  input wire [2:0]  active_set_q,
  input wire        fault_q,
  input wire [3:0]  diag_code_q
);
  // until ctrl is written the reset setting holds: fixed mode, interlocks on
  reg cfg_q;
  reg btn_q;
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_q <= 1'b0;
      btn_q <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == 8'h00) cfg_q <= 1'b1;
      if (reset_btn) btn_q <= 1'b1;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  a_fault_sticky: assert property (fault_q |=> fault_q)
    else $error("fault flag dropped");
  a_fault_off: assert property (fault_q |=> safety_output_pair_q == 2'h0)
    else $error("outputs on during fault");
  a_diag_given: assert property (fault_q |-> diag_code_q != 4'h0)
    else $error("fault without diagnostic");
  a_diag_hold: assert property (fault_q |=> $stable(diag_code_q))
    else $error("diagnostic changed in fault");
  a_pair_match: assert property (safety_output_pair_q[0] == safety_output_pair_q[1])
    else $error("output pair split");
  a_fixed_set: assert property (!cfg_q |-> active_set_q == 3'h0)
    else $error("fixed mode left default set");
  a_start_lock: assert property (!cfg_q && !btn_q |-> safety_output_pair_q == 2'h0)
    else $error("outputs on without press");
  a_zone_off: assert property (!cfg_q && zone_violated[0] |=> safety_output_pair_q == 2'h0)
    else $error("outputs on with zone violated");
  cover property ($rose(fault_q));
  cover property ($rose(safety_output_pair_q[0]));
  cover property ($changed(active_set_q));
endmodule // zsrg_checker
bind zsrg_guard zsrg_checker u_chk (.sys_clk(sys_clk), .rst_b(rst_b), .reset_btn(reset_btn),
  .zone_violated(zone_violated), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .safety_output_pair_q(safety_output_pair_q), .active_set_q(active_set_q),
  .fault_q(fault_q), .diag_code_q(diag_code_q));

// *** dv/zsrg_ctrl_model.sv ***
// Safety controller model driving the four zone-select pins.
// Assumes requests change just after a clock edge.
`timescale 1ns/10ps
module zsrg_ctrl_model (
  input  wire       sys_clk,
  input  wire [3:0] req_pat,
  input  wire       slow,
  output wire       zone_sel_in_1,
  output wire       zone_sel_in_2,
  output wire       zone_sel_in_3,
  output wire       zone_sel_in_4
);
  reg [3:0] pin_q = 4'h0;
  reg       lag_q = 1'b0;
  // slow wiring lets the first pin trail by a cycle, well inside the switchover time
  always @(posedge sys_clk) begin
    lag_q <= req_pat[3];
    pin_q <= {slow ? lag_q : req_pat[3], req_pat[2:0]};
  end
  assign {zone_sel_in_1, zone_sel_in_2, zone_sel_in_3, zone_sel_in_4} = pin_q;
endmodule // zsrg_ctrl_model

// *** dv/zsrg_guard_tb.sv ***
// Testbench for zsrg_guard: decode table, interlocks, changeover faults.
// Assumes select pins come from zsrg_ctrl_model; press limits shortened.
`timescale 1ns/10ps
module zsrg_guard_tb;
  reg         sys_clk, rst_b, reset_btn, reg_wr, reg_rd, slow;
  reg  [7:0]  zone_violated, reg_addr;
  reg  [31:0] reg_wdata;
  reg  [3:0]  req_pat;
  reg  [2:0]  prev;
  wire        s1, s2, s3, s4, fault_q;
  wire [31:0] rdata;
  wire [1:0]  outs;
  wire [2:0]  set;
  wire [3:0]  diag;
  integer     fails = 0, n_checks = 0, i;
  // {mode, pattern in1..in4, expected set}
  localparam logic [0:14][8:0] ROWS = {9'h1C0, 9'h1A1, 9'h192, 9'h18B, 9'h1F4, 9'h1ED,
    9'h1DE, 9'h1BF, 9'h110, 9'h121, 9'h142, 9'h173, 9'h0C0, 9'h0A1, 9'h078};
  zsrg_guard #(.PRESS_MIN_CYC(20), .PRESS_MAX_CYC(200), .SYNC_CYC(10)) dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .reset_btn(reset_btn), .zone_sel_in_1(s1),
    .zone_sel_in_2(s2), .zone_sel_in_3(s3), .zone_sel_in_4(s4),
    .zone_violated(zone_violated), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(rdata), .safety_output_pair_q(outs),
    .active_set_q(set), .fault_q(fault_q), .diag_code_q(diag));
  zsrg_ctrl_model u_ctl (.sys_clk(sys_clk), .req_pat(req_pat), .slow(slow),
    .zone_sel_in_1(s1), .zone_sel_in_2(s2), .zone_sel_in_3(s3), .zone_sel_in_4(s4));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task cyc(input integer n);
    repeat (n) @(posedge sys_clk);
  endtask
  task chk(input [63:0] nm, input logic [31:0] got, exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("[FAIL] %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge sys_clk);
      reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [31:0] e, input [63:0] nm);
    begin
      @(posedge sys_clk);
      reg_rd <= 1'b1; reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 chk(nm, rdata, e);
    end
  endtask
  task press(input integer n);
    begin
      @(posedge sys_clk);
      reset_btn <= 1'b1;
      cyc(n);
      reset_btn <= 1'b0;
      cyc(8);
    end
  endtask
  task pick(input [3:0] p);
    begin
      @(posedge sys_clk);
      req_pat <= p;
    end
  endtask
  task do_reset;
    begin
      @(posedge sys_clk);
      req_pat <= 4'h0; zone_violated <= 8'h00; rst_b <= 1'b0;
      cyc(4);
      rst_b <= 1'b1;
      cyc(2);
    end
  endtask
  task fault_case(input [31:0] c, input [7:0] a, input [31:0] d, input [3:0] p1, p2, dg);
    begin
      do_reset;
      wr(8'h00, c); wr(8'h04, 32'h8); wr(a, d);
      pick(p1); cyc(30);
      pick(p2); cyc(30);
      chk("fault", fault_q, 1); chk("diag", diag, dg); chk("outs", outs, 0);
      pick(p1); cyc(30);
      chk("sticky", fault_q, 1);
    end
  endtask
  task complete_run;
    begin
      $display("comparisons %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  initial begin
    cyc(20000);
    fails = fails + 1;
    complete_run;
  end
  initial begin
    rst_b = 1'b0; reset_btn = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; slow = 1'b0;
    zone_violated = 8'h00; reg_addr = 8'h00; reg_wdata = 32'h0; req_pat = 4'h0; prev = 3'h0;
    cyc(20);
    rst_b <= 1'b1;
    wr(8'h04, 32'h8);
    for (i = 0; i < 15; i = i + 1) begin
      wr(8'h00, {27'h0, ROWS[i][8:7], 2'h0});
      @(posedge sys_clk);
      slow <= i[0]; req_pat <= ROWS[i][6:3];
      cyc(6);
      if (ROWS[i][8:7] != 2'h0) chk("hold", set, prev);
      cyc(24);
      chk("set", set, ROWS[i][2:0]);
      prev = ROWS[i][2:0];
    end
    $display("decode done");
    do_reset;
    rd(8'h00, 32'h3, "ctrl");
    rd(8'h04, 32'h61A8, "swtime");
    rd(8'hFC, 32'h0, "unmapped");
    press(10); chk("short", outs, 0);
    press(250); chk("long", outs, 0);
    press(50); chk("press", outs, 3);
    zone_violated <= 8'h01; cyc(3); chk("viol", outs, 0);
    zone_violated <= 8'h00; cyc(20); chk("relock", outs, 0);
    press(50); chk("rearm", outs, 3);
    do_reset; wr(8'h00, 32'h2); cyc(30); chk("rstonly", outs, 0);
    press(50); chk("rstpress", outs, 3);
    $display("interlock done");
    fault_case(32'hC, 8'h14, 32'h0, 4'h8, 4'hC, 4'h1);
    fault_case(32'h1C, 8'h0C, 32'h2, 4'h8, 4'h2, 4'h2);
    fault_case(32'h1C, 8'h14, 32'h80, 4'h8, 4'h7, 4'h3);
    $display("faults done");
    do_reset; wr(8'h00, 32'hC); wr(8'h04, 32'h8); wr(8'h08, 32'h4);
    pick(4'h8); cyc(30);
    zone_violated <= 8'h02;
    pick(4'h4); cyc(20); chk("late", outs, 3);
    cyc(30); chk("off", outs, 0);
    $display("occupied done");
    complete_run;
  end
endmodule // zsrg_guard_tb
